// ==== inc/tbpic_pkg.sv ====
package tbpic_pkg;
   // Telegram control/status codes and the update constant
   localparam logic [7:0] CS_UPDATE = 8'h10;
   localparam logic [7:0] CS_ACCESS = 8'h30;
   localparam logic [7:0] UPDATE_DATA = 8'h80;
   // Process image geometry
   localparam int IMG_WORDS = 256;
   localparam int AW = 8;
   // Parameter byte bit positions for mode and options
   localparam int B9_FAST_POS = 4;
   localparam int B9_FREE_POS = 6;
   localparam int B12_OPT1_POS = 0;
   localparam int B12_OPT2_POS = 1;
   localparam int B3_CNT_POS = 3;
   // Analog channel layout and resolution handling
   localparam int ANA_CH_BYTES = 4;
   localparam logic [15:0] RES12_MASK = 16'hfff8;
   // Terminal data limit per terminal-bus cycle
   localparam logic [7:0] SEG_LIM_STD = 8'h06;
   localparam logic [7:0] SEG_LIM_GW = 8'h0c;
   // Cycle time estimate figures in microseconds
   localparam logic [19:0] EST_BASE_US = 20'h00258;
   localparam logic [19:0] EST_AI_US = 20'h00020;
   localparam logic [19:0] EST_AO_US = 20'h0002a;
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int NS_PER_US = 1000;
   localparam int CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
   localparam int SLOW_GAP_US_DEF = 1000;
   // Terminal kinds reported during discovery
   localparam logic [1:0] K_AO = 2'h0;
   localparam logic [1:0] K_DO = 2'h1;
   localparam logic [1:0] K_AI = 2'h2;
   localparam logic [1:0] K_DI = 2'h3;
   // Reset values
   localparam logic [7:0] CYC_CTR_RST = 8'h00;
   localparam logic [15:0] DLY_RST = 16'h0000;
   typedef enum logic [2:0] {
      MODE_SLOW, MODE_FAST, MODE_SYNC, MODE_OPT1, MODE_OPT2
   } tbpic_mode_t;
   typedef enum logic [3:0] {
      ST_DISC_REQ, ST_DISC_WAIT, ST_IDLE, ST_WAIT_DLY, ST_COPY_OUT,
      ST_LATCH_IN, ST_SEND, ST_READ, ST_LATCH_OUT, ST_COPY_IN
   } tbpic_state_t;
endpackage : tbpic_pkg

// ==== src/tbpic_core.sv ====
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
// Overview of operation
// - Two 256-word images, every word addressable
// - Update only on code 0x10 with 0x80
// - Code 0x30 writes and reads one word
// - Discover terminals after reset, assign addresses
// - Inputs, outputs separate; bytes before bits
// - One bit per digital channel, sent on update; assigned digital addresses step eight bits per earlier channel
// - Analog word is signed, 0x7FFF full scale
// - 12-bit channels: low three bits dropped
// - Analog channel four bytes, control byte high
// - Assign channels from nearest terminal onwards
// - Order: AO, DO, AI, DI groups
// - Complex terminals mapped as analog, any width
// - Cycle phases run in fixed order
// - Large or four-channel terminals need more cycles
// - Report estimated cycle time from formula
// - Measure each cycle's duration for the master
// - Cycle free-running or synchronised per mode
// - Mode decoded from parameter bytes 9, 12
// - Synchronous mode starts cycle on telegram
// - One-cycle mode delays start by parameter
// - Two-cycle mode: second cycle after delay
// - Cycle counter skips zero, 255 to 1
module tbpic_core #(
   parameter int MAX_TERM = 64,
   parameter int SLOW_GAP_US = tbpic_pkg::SLOW_GAP_US_DEF
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Fieldbus telegrams
   input wire logic tg_valid,
   input wire logic [7:0] tg_ctrl,
   input wire logic [tbpic_pkg::AW-1:0] tg_addr,
   input wire logic [15:0] tg_wdata,
   output logic tg_rvalid,
   output logic [15:0] tg_rdata,
   // User parameter bytes
   input wire logic prm_valid,
   input wire logic [7:0] user_parameter_bytes_3,
   input wire logic [7:0] user_parameter_bytes_9,
   input wire logic [7:0] user_parameter_bytes_12,
   input wire logic [7:0] user_parameter_bytes_13,
   input wire logic [7:0] user_parameter_bytes_14,
   // Terminal discovery
   output logic dq_req,
   output logic [7:0] dq_idx,
   input wire logic dq_present,
   input wire logic [1:0] dq_kind,
   input wire logic [7:0] dq_size,
   input wire logic dq_res12,
   input wire logic dq_four_ch,
   input wire logic dq_gateway,
   output logic asg_valid,
   output logic [7:0] asg_idx,
   output logic [10:0] asg_addr,
   // Terminal bus exchange
   output logic kb_latch_in,
   output logic kb_latch_out,
   output logic kb_wr,
   output logic kb_rd,
   output logic [tbpic_pkg::AW-1:0] kb_addr,
   output logic [15:0] kb_wdata,
   output logic [2:0] kb_seg,
   input wire logic [15:0] kb_rdata,
   // Status
   output logic map_ready,
   output logic cyc_busy,
   output logic [2:0] mode_out,
   output logic [7:0] cyc_ctr,
   output logic [19:0] meas_cycle_us,
   output logic [19:0] est_cycle_us
);
   import tbpic_pkg::*;

   typedef struct packed {
      tbpic_state_t st;
      tbpic_mode_t mode;
      logic cnt_en;
      logic [15:0] dly_us;
      logic pass;
      logic [7:0] idx;
      logic [10:0] ao_b, ai_b, do_n, di_n, ao_p, ai_p, do_p, di_p;
      logic [7:0] ao_ch, ai_ch;
      logic [2:0] segs, seg;
      logic [IMG_WORDS-1:0] res_o, res_i;
      logic [IMG_WORDS-1:0][15:0] out_img, in_img, out_stg, in_stg;
      logic [AW:0] widx, n_out, n_in;
      logic rd_pend;
      logic [AW-1:0] rd_addr;
      logic pend, second;
      logic [6:0] presc;
      logic [19:0] tmr_us, run_us, prev_us;
      logic tg_rvalid;
      logic [15:0] tg_rdata;
      logic dq_req;
      logic asg_valid;
      logic [7:0] asg_idx;
      logic [10:0] asg_addr;
      logic kb_latch_in, kb_latch_out, kb_wr, kb_rd;
      logic [AW-1:0] kb_addr;
      logic [15:0] kb_wdata;
      logic map_ready, busy;
      logic [7:0] cyc_ctr;
      logic [19:0] meas_us, est_us;
   } tbpic_state_s_t;

   tbpic_state_s_t q, d;
   logic us_tick;
   logic upd_cmd;
   logic [10:0] sz, base;
   logic [7:0] lim;
   logic [2:0] need;
   logic [10:0] do_bytes, di_bytes;
   logic [19:0] dig_us;

   assign us_tick = (q.presc == 7'(CYC_PER_US - 1));
   assign upd_cmd = tg_valid && (tg_ctrl == CS_UPDATE) && (tg_wdata[7:0] == UPDATE_DATA);

   always_comb begin
      d = q;
      sz = {3'h0, dq_size};
      base = 11'h000;
      lim = dq_gateway ? SEG_LIM_GW : SEG_LIM_STD;
      need = 3'h1;
      do_bytes = (q.do_n + 11'h007) >> 3;
      di_bytes = (q.di_n + 11'h007) >> 3;
      dig_us = 20'((({9'h000, q.do_n} + {9'h000, q.di_n}) * 20'h00005) >> 1);
      d.presc = us_tick ? 7'h00 : q.presc + 7'h01;
      d.tmr_us = us_tick ? q.tmr_us + 20'h00001 : q.tmr_us;
      d.tg_rvalid = 1'b0;
      d.dq_req = 1'b0;
      d.asg_valid = 1'b0;
      d.kb_latch_in = 1'b0;
      d.kb_latch_out = 1'b0;
      d.kb_wr = 1'b0;
      d.kb_rd = 1'b0;
      if (q.busy && us_tick) begin
         d.run_us = q.run_us + 20'h00001;
      end
      // Parameter acceptance fixes the mode until the next set
      if (prm_valid) begin
         unique case ({user_parameter_bytes_9[B9_FAST_POS], user_parameter_bytes_9[B9_FREE_POS],
                       user_parameter_bytes_12[B12_OPT1_POS], user_parameter_bytes_12[B12_OPT2_POS]})
            4'b0100: d.mode = MODE_SLOW;
            4'b1100: d.mode = MODE_FAST;
            4'b0000: d.mode = MODE_SYNC;
            4'b0010: d.mode = MODE_OPT1;
            4'b0001: d.mode = MODE_OPT2;
            default: d.mode = MODE_SLOW;
         endcase
         d.cnt_en = user_parameter_bytes_3[B3_CNT_POS];
         d.dly_us = {user_parameter_bytes_13, user_parameter_bytes_14};
      end
      // Master data access: write output word, read input word together
      if (tg_valid && tg_ctrl == CS_ACCESS) begin
         d.out_img[tg_addr] = tg_wdata;
         d.tg_rdata = q.in_img[tg_addr];
         d.tg_rvalid = 1'b1;
      end
      if (upd_cmd && q.map_ready) begin
         d.pend = 1'b1;
      end
      unique case (q.st)
         ST_DISC_REQ: begin
            d.dq_req = 1'b1;
            d.st = ST_DISC_WAIT;
         end
         ST_DISC_WAIT: begin
            if (!dq_present || q.idx == 8'(MAX_TERM)) begin
               d.idx = 8'h00;
               if (!q.pass) begin
                  d.pass = 1'b1;
                  d.do_p = q.ao_b;
                  d.di_p = q.ai_b;
                  d.st = ST_DISC_REQ;
               end else begin
                  // Words per area: byte region then packed bit region
                  d.n_out = (AW+1)'((q.ao_b + do_bytes + 11'h001) >> 1);
                  d.n_in = (AW+1)'((q.ai_b + di_bytes + 11'h001) >> 1);
                  d.est_us = 20'(q.segs) * (EST_BASE_US + dig_us + EST_AI_US * 20'(q.ai_ch)
                             + EST_AO_US * 20'(q.ao_ch));
                  d.map_ready = 1'b1;
                  d.tmr_us = 20'h00000;
                  d.st = ST_IDLE;
               end
            end else begin
               d.idx = q.idx + 8'h01;
               d.st = ST_DISC_REQ;
               if (dq_kind == K_AO || dq_kind == K_AI) begin
                  sz = (sz + 11'h001) & 11'h7fe;
               end
               if (!q.pass) begin
                  // First pass sizes the byte regions and the cycle count
                  unique case (dq_kind)
                     K_AO: begin
                        d.ao_b = q.ao_b + sz;
                        d.ao_ch = q.ao_ch + 8'(sz >> 2);
                     end
                     K_AI: begin
                        d.ai_b = q.ai_b + sz;
                        d.ai_ch = q.ai_ch + 8'(sz >> 2);
                     end
                     K_DO: d.do_n = q.do_n + sz;
                     K_DI: d.di_n = q.di_n + sz;
                  endcase
                  if (dq_size > 8'(lim * 8'h03)) need = 3'h4;
                  else if (dq_size > 8'(lim * 8'h02)) need = 3'h3;
                  else if (dq_size > lim || dq_four_ch) need = 3'h2;
                  if (need > q.segs) d.segs = need;
               end else begin
                  // Second pass hands out addresses left to right, per group
                  unique case (dq_kind)
                     K_AO: begin
                        base = q.ao_p;
                        d.ao_p = q.ao_p + sz;
                     end
                     K_DO: begin
                        base = q.do_p;
                        d.do_p = q.do_p + sz;
                     end
                     K_AI: begin
                        base = q.ai_p;
                        d.ai_p = q.ai_p + sz;
                     end
                     K_DI: begin
                        base = q.di_p;
                        d.di_p = q.di_p + sz;
                     end
                  endcase
                  // Digital base is a bit address after the byte region
                  d.asg_addr = (dq_kind == K_DO) ? (((base - q.ao_b) << 3) + (q.ao_b << 3)) :
                               (dq_kind == K_DI) ? (((base - q.ai_b) << 3) + (q.ai_b << 3)) : base;
                  d.asg_idx = q.idx;
                  d.asg_valid = 1'b1;
                  if (dq_res12 && (dq_kind == K_AO || dq_kind == K_AI)) begin
                     for (int w = 0; w < IMG_WORDS; w++) begin
                        if (11'(w * 2) >= base && 11'(w * 2) < base + sz
                            && ((11'(w * 2) - base) & 11'(ANA_CH_BYTES - 1)) == 11'h000) begin
                           if (dq_kind == K_AO) d.res_o[w] = 1'b1;
                           else d.res_i[w] = 1'b1;
                        end
                     end
                  end
               end
            end
         end
         ST_IDLE: begin
            unique case (q.mode)
               MODE_SLOW: if (q.tmr_us >= 20'(SLOW_GAP_US)) d.st = ST_COPY_OUT;
               MODE_FAST: if (q.tmr_us >= (q.prev_us >> 3)) d.st = ST_COPY_OUT;
               MODE_SYNC: if (q.pend) d.st = ST_COPY_OUT;
               MODE_OPT1: if (q.pend) begin
                  d.tmr_us = 20'h00000;
                  d.presc = 7'h00;
                  d.st = ST_WAIT_DLY;
               end
               MODE_OPT2: if (q.pend) begin
                  d.second = 1'b1;
                  d.st = ST_COPY_OUT;
               end
            endcase
            if (q.pend) d.pend = upd_cmd;
         end
         ST_WAIT_DLY: begin
            if (q.tmr_us >= {4'h0, q.dly_us}) d.st = ST_COPY_OUT;
         end
         ST_COPY_OUT: begin
            d.out_stg = q.out_img;
            d.busy = 1'b1;
            d.run_us = 20'h00000;
            d.seg = 3'h0;
            d.st = ST_LATCH_IN;
         end
         ST_LATCH_IN: begin
            d.kb_latch_in = 1'b1;
            d.widx = '0;
            d.st = (q.n_out == '0) ? ST_READ : ST_SEND;
         end
         ST_SEND: begin
            d.kb_wr = 1'b1;
            d.kb_addr = q.widx[AW-1:0];
            d.kb_wdata = q.res_o[q.widx[AW-1:0]] ? (q.out_stg[q.widx[AW-1:0]] & RES12_MASK)
                         : q.out_stg[q.widx[AW-1:0]];
            d.widx = q.widx + 1'b1;
            if (q.widx + 1'b1 == q.n_out) begin
               d.widx = '0;
               d.st = ST_READ;
            end
         end
         ST_READ: begin
            if (q.widx < q.n_in) begin
               d.kb_rd = 1'b1;
               d.kb_addr = q.widx[AW-1:0];
               d.widx = q.widx + 1'b1;
            end else if (!q.rd_pend) begin
               if (q.seg + 3'h1 < q.segs) begin
                  d.seg = q.seg + 3'h1;
                  d.widx = '0;
                  d.st = (q.n_out == '0) ? ST_READ : ST_SEND;
               end else begin
                  d.st = ST_LATCH_OUT;
               end
            end
         end
         ST_LATCH_OUT: begin
            d.kb_latch_out = 1'b1;
            d.st = ST_COPY_IN;
         end
         ST_COPY_IN: begin
            d.in_img = q.in_stg;
            d.busy = 1'b0;
            d.meas_us = q.run_us;
            d.prev_us = q.run_us;
            // Restart the prescaler so a gap is never shorter than its count
            d.tmr_us = 20'h00000;
            d.presc = 7'h00;
            if (q.cnt_en) d.cyc_ctr = (q.cyc_ctr == 8'hff) ? 8'h01 : q.cyc_ctr + 8'h01;
            if (q.second && q.mode == MODE_OPT2) begin
               d.second = 1'b0;
               d.st = ST_WAIT_DLY;
            end else begin
               d.second = 1'b0;
               d.st = ST_IDLE;
            end
         end
      endcase
      // Read answers are taken in the same clock that kb_rd is high
      d.rd_pend = d.kb_rd;
      d.rd_addr = d.kb_addr;
      if (q.rd_pend) begin
         d.in_stg[q.rd_addr] = q.res_i[q.rd_addr] ? (kb_rdata & RES12_MASK) : kb_rdata;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         q <= '0;
         q.st <= ST_DISC_REQ;
         q.mode <= MODE_SLOW;
         q.dly_us <= DLY_RST;
         q.cyc_ctr <= CYC_CTR_RST;
         q.segs <= 3'h1;
      end else begin
         q <= d;
      end
   end

   assign tg_rvalid = q.tg_rvalid;
   assign tg_rdata = q.tg_rdata;
   assign dq_req = q.dq_req;
   assign dq_idx = q.idx;
   assign asg_valid = q.asg_valid;
   assign asg_idx = q.asg_idx;
   assign asg_addr = q.asg_addr;
   assign kb_latch_in = q.kb_latch_in;
   assign kb_latch_out = q.kb_latch_out;
   assign kb_wr = q.kb_wr;
   assign kb_rd = q.kb_rd;
   assign kb_addr = q.kb_addr;
   assign kb_wdata = q.kb_wdata;
   assign kb_seg = q.seg;
   assign map_ready = q.map_ready;
   assign cyc_busy = q.busy;
   assign mode_out = q.mode;
   assign cyc_ctr = q.cyc_ctr;
   assign meas_cycle_us = q.meas_us;
   assign est_cycle_us = q.est_us;

   sequence s_access;
      tg_valid && tg_ctrl == CS_ACCESS;
   endsequence
   sequence s_sync_upd;
      upd_cmd && q.map_ready && q.mode == MODE_SYNC && q.st == ST_IDLE && !prm_valid;
   endsequence
   AST_ACCESS_ANSWER: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_access |=> tg_rvalid && tg_rdata == $past(q.in_img[tg_addr]))
      else $error("access answer missing or wrong");
   AST_UPDATE_ONLY: assert property (@(posedge clk_sys) disable iff (!resetn)
      tg_valid && tg_ctrl == CS_UPDATE && tg_wdata[7:0] != UPDATE_DATA && !q.pend |=> !q.pend)
      else $error("update taken without constant");
   AST_SYNC_START: assert property (@(posedge clk_sys) disable iff (!resetn)
      s_sync_upd |=> ##1 q.st == ST_COPY_OUT ##1 kb_latch_in == 1'b0 ##1 kb_latch_in)
      else $error("sync cycle not started");
   AST_PHASE_ORDER: assert property (@(posedge clk_sys) disable iff (!resetn)
      q.st == ST_COPY_OUT |=> q.st == ST_LATCH_IN ##1 kb_latch_in)
      else $error("latch inputs out of order");
   AST_WR_IN_SEND: assert property (@(posedge clk_sys) disable iff (!resetn)
      kb_wr |-> $past(q.st) == ST_SEND)
      else $error("write outside send phase");
   AST_CTR_SKIP0: assert property (@(posedge clk_sys) disable iff (!resetn)
      q.st == ST_COPY_IN && q.cnt_en && cyc_ctr == 8'hff |=> cyc_ctr == 8'h01)
      else $error("counter did not skip zero");
   AST_MODE_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      !$past(prm_valid) |-> $stable(mode_out))
      else $error("mode changed without parameters");
   AST_RES12_SEND: assert property (@(posedge clk_sys) disable iff (!resetn)
      kb_wr && q.res_o[kb_addr] |-> kb_wdata[2:0] == 3'h0)
      else $error("12-bit channel low bits sent");
   AST_MEAS: assert property (@(posedge clk_sys) disable iff (!resetn)
      q.st == ST_COPY_IN |=> meas_cycle_us == $past(q.run_us))
      else $error("cycle time not captured");
endmodule : tbpic_core

// ==== bench/tbpic_term_model.sv ====
`timescale 1ns/1ps
module tbpic_term_model (
   // Clock
   input wire logic clk_sys,
   // Discovery
   input wire logic dq_req,
   input wire logic [7:0] dq_idx,
   output logic dq_present,
   output logic [1:0] dq_kind,
   output logic [7:0] dq_size,
   output logic dq_res12,
   output logic dq_four_ch,
   output logic dq_gateway,
   // Terminal bus
   input wire logic kb_rd,
   output logic [15:0] kb_rdata
);
   import tbpic_pkg::*;
   // Chain from the coupler: AO 4 bytes, DO 2 ch, AI 4 bytes, DI 4 ch, then end
   logic [1:0] kinds [4] = '{K_AO, K_DO, K_AI, K_DI};
   logic [7:0] sizes [4] = '{8'h04, 8'h02, 8'h04, 8'h04};
   logic [13:0] ans;
   assign ans = {dq_idx < 8'h04, kinds[dq_idx[1:0]], sizes[dq_idx[1:0]], ~dq_idx[0], 2'b00};
   // Answer stands while the query does, since the core samples it then; inverted otherwise
   assign {dq_present, dq_kind, dq_size, dq_res12, dq_four_ch, dq_gateway} = dq_req ? ans : ~ans;
   assign kb_rdata = kb_rd ? 16'h5a5f : 16'ha5a0;
endmodule : tbpic_term_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
   import tbpic_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic tg_valid = 1'b0;
   logic [7:0] tg_ctrl = 8'h00;
   logic [AW-1:0] tg_addr = '0;
   logic [15:0] tg_wdata = 16'h0000;
   logic prm_valid = 1'b0;
   logic [7:0] pb3 = 8'h00;
   logic [7:0] pb9 = 8'h00;
   logic [7:0] pb12 = 8'h00;
   logic [7:0] pb13 = 8'h00;
   logic [7:0] pb14 = 8'h00;
   logic tg_rvalid, dq_req, dq_present, dq_res12, dq_four_ch, dq_gateway, asg_valid;
   logic kb_latch_in, kb_latch_out, kb_wr, kb_rd, map_ready, cyc_busy;
   logic [15:0] tg_rdata, kb_wdata, kb_rdata, rd;
   logic [7:0] dq_idx, dq_size, asg_idx, cyc_ctr, c0;
   logic [7:0] ctr_q = 8'h00;
   logic [1:0] dq_kind;
   logic [10:0] asg_addr;
   logic [AW-1:0] kb_addr;
   logic [2:0] kb_seg, mode_out;
   logic [19:0] meas_cycle_us, est_cycle_us;
   logic [15:0] wd [0:255];
   logic saw_wr = 1'b0;
   logic saw_rd = 1'b0;
   logic wrapped = 1'b0;
   int error_cnt = 0;
   int tests_run = 0;
   int li_cnt = 0;
   int asg_cnt = 0;
   int n, base;
   logic [7:0] m9 [6] = '{8'h40, 8'h50, 8'h00, 8'h00, 8'h00, 8'h10};
   logic [7:0] m12 [6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
   logic [2:0] mexp [6] = '{MODE_SLOW, MODE_FAST, MODE_SYNC, MODE_OPT1, MODE_OPT2, MODE_SLOW};

   always #5 clk_sys = ~clk_sys;

   tbpic_core #(.MAX_TERM(64), .SLOW_GAP_US(5)) u_dut (
      .clk_sys(clk_sys), .resetn(resetn), .tg_valid(tg_valid), .tg_ctrl(tg_ctrl), .tg_addr(tg_addr),
      .tg_wdata(tg_wdata), .tg_rvalid(tg_rvalid), .tg_rdata(tg_rdata), .prm_valid(prm_valid),
      .user_parameter_bytes_3(pb3), .user_parameter_bytes_9(pb9), .user_parameter_bytes_12(pb12),
      .user_parameter_bytes_13(pb13), .user_parameter_bytes_14(pb14), .dq_req(dq_req), .dq_idx(dq_idx),
      .dq_present(dq_present), .dq_kind(dq_kind), .dq_size(dq_size), .dq_res12(dq_res12),
      .dq_four_ch(dq_four_ch), .dq_gateway(dq_gateway), .asg_valid(asg_valid), .asg_idx(asg_idx),
      .asg_addr(asg_addr), .kb_latch_in(kb_latch_in), .kb_latch_out(kb_latch_out), .kb_wr(kb_wr),
      .kb_rd(kb_rd), .kb_addr(kb_addr), .kb_wdata(kb_wdata), .kb_seg(kb_seg), .kb_rdata(kb_rdata),
      .map_ready(map_ready), .cyc_busy(cyc_busy), .mode_out(mode_out), .cyc_ctr(cyc_ctr),
      .meas_cycle_us(meas_cycle_us), .est_cycle_us(est_cycle_us)
   );

   tbpic_term_model u_term (
      .clk_sys(clk_sys), .dq_req(dq_req), .dq_idx(dq_idx), .dq_present(dq_present), .dq_kind(dq_kind),
      .dq_size(dq_size), .dq_res12(dq_res12), .dq_four_ch(dq_four_ch), .dq_gateway(dq_gateway),
      .kb_rd(kb_rd), .kb_rdata(kb_rdata)
   );

   task chk(input logic [19:0] got, input logic [19:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t %s", $time, what);
      end
   endtask : chk

   task conclude;
      $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : conclude

   task tg(input logic [7:0] c, input logic [7:0] a, input logic [15:0] d, input logic rv);
      @(posedge clk_sys);
      tg_valid <= 1'b1;
      tg_ctrl <= c;
      tg_addr <= a;
      tg_wdata <= d;
      @(posedge clk_sys);
      tg_valid <= 1'b0;
      #1;
      chk(20'(tg_rvalid), 20'(rv), "answer strobe");
      rd = tg_rdata;
   endtask : tg

   task prm(input logic [7:0] b3, input logic [7:0] b9, input logic [7:0] b12, input logic [7:0] b14);
      @(posedge clk_sys);
      prm_valid <= 1'b1;
      pb3 <= b3;
      pb9 <= b9;
      pb12 <= b12;
      pb13 <= 8'h00;
      pb14 <= b14;
      @(posedge clk_sys);
      prm_valid <= 1'b0;
      repeat (2) @(posedge clk_sys);
   endtask : prm

   task wait_li(input int max);
      base = li_cnt;
      n = 0;
      while (li_cnt == base && n < max) begin
         @(posedge clk_sys);
         n++;
      end
   endtask : wait_li

   task wait_idle;
      n = 0;
      while (cyc_busy !== 1'b0 && n < 5000) begin
         @(posedge clk_sys);
         n++;
      end
   endtask : wait_idle

   // Terminal-side monitor
   always @(posedge clk_sys) begin
      ctr_q <= cyc_ctr;
      if (kb_latch_in) begin
         li_cnt <= li_cnt + 1;
         saw_wr <= 1'b0;
         saw_rd <= 1'b0;
      end
      if (kb_wr) begin
         wd[kb_addr] <= kb_wdata;
         saw_wr <= 1'b1;
         chk(20'(saw_rd), 20'h0, "write after read");
      end
      if (kb_rd)
         saw_rd <= 1'b1;
      if (kb_latch_out)
         chk(20'(saw_wr & saw_rd), 20'h1, "phase order");
      if (asg_valid) begin
         asg_cnt <= asg_cnt + 1;
         chk(20'(asg_addr), asg_idx[0] ? 20'h00020 : 20'h00000, "assigned address");
      end
      if (resetn && cyc_ctr !== ctr_q) begin
         chk(20'(cyc_ctr), (ctr_q == 8'hff) ? 20'h1 : 20'(ctr_q + 8'h01), "cycle counter");
         if (ctr_q == 8'hff)
            wrapped <= 1'b1;
      end
   end

   initial begin
      #500000;
      error_cnt++;
      conclude();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      #1;
      chk(20'({map_ready, cyc_busy, tg_rvalid, mode_out}), 20'h0, "reset outputs");
      @(posedge clk_sys);
      #1;
      chk(20'({dq_req, dq_idx}), 20'h100, "discovery start");
      n = 0;
      while (map_ready !== 1'b1 && n < 3000) begin
         @(posedge clk_sys);
         n++;
      end
      chk(20'(map_ready), 20'h1, "map ready");
      chk(20'(asg_cnt), 20'h4, "assignments");
      chk(est_cycle_us, 20'h002b1, "estimate");
      $display("test discovery done");
      for (int i = 0; i < 6; i++) begin
         prm(8'h08, m9[i], m12[i], 8'h00);
         chk(20'(mode_out), 20'(mexp[i]), "mode decode");
      end
      prm(8'h08, 8'h00, 8'h00, 8'h00);
      @(posedge clk_sys);
      pb9 <= 8'h40;
      repeat (3) @(posedge clk_sys);
      chk(20'(mode_out), 20'(MODE_SYNC), "mode held");
      $display("test modes done");
      wait_idle();
      // Two-word write with no update in between
      tg(CS_ACCESS, 8'h00, 16'h1237, 1'b1);
      tg(CS_ACCESS, 8'h02, 16'h0003, 1'b1);
      tg(8'h20, 8'h00, 16'h0000, 1'b0);
      tg(CS_UPDATE, 8'h00, 16'h007f, 1'b0);
      wait_li(600);
      chk(20'(n >= 600), 20'h1, "no cycle");
      c0 = cyc_ctr;
      tg(CS_UPDATE, 8'h00, 16'h0080, 1'b0);
      wait_li(20);
      chk(20'(n < 20), 20'h1, "sync start");
      wait_idle();
      chk(20'(wd[0]), 20'h01230, "analog out");
      chk(20'(wd[2][1:0]), 20'h3, "digital out");
      chk(20'(cyc_ctr), 20'(c0 + 8'h01), "count step");
      tg(CS_ACCESS, 8'h00, 16'h1237, 1'b1);
      chk(20'(rd), 20'h05a58, "analog in");
      $display("test sync done");
      prm(8'h08, 8'h00, 8'h01, 8'h03);
      tg(CS_UPDATE, 8'h00, 16'h0080, 1'b0);
      wait_li(400);
      chk(20'(n >= 300 && n <= 320), 20'h1, "one-cycle delay");
      wait_idle();
      prm(8'h08, 8'h00, 8'h02, 8'h02);
      tg(CS_UPDATE, 8'h00, 16'h0080, 1'b0);
      wait_li(20);
      chk(20'(n < 20), 20'h1, "first cycle");
      wait_idle();
      wait_li(300);
      chk(20'(n >= 200 && n <= 220), 20'h1, "second cycle");
      $display("test optimised done");
      prm(8'h08, 8'h40, 8'h00, 8'h00);
      base = li_cnt;
      repeat (4000) @(posedge clk_sys);
      chk(20'(li_cnt - base >= 2 && li_cnt - base <= 8), 20'h1, "slow repeat");
      prm(8'h08, 8'h50, 8'h00, 8'h00);
      n = 0;
      while (wrapped !== 1'b1 && n < 80000) begin
         @(posedge clk_sys);
         n++;
      end
      chk(20'(wrapped), 20'h1, "counter wrap");
      $display("test unsynced done");
      conclude();
   end
endmodule : testbench
